/* qfcd_regs.vh */
// Purpose: Constants of the flash command decoder.
// Assumes: Serial link sampled by a 200 MHz system clock.
// Notes: Opcodes, mode widths and address limits.
`ifndef QFCD_REGS_VH
`define QFCD_REGS_VH
`define OP_NOP 8'h00
`define OP_RESET_ARM 8'h66
`define OP_RESET_EXEC 8'h99
`define OP_QUAD_ENTER 8'h38
`define OP_QUAD_EXIT 8'hff
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hd8
`define OP_CHIP_ERASE 8'hc7
`define OP_PAGE_PROG 8'h02
`define OP_QUAD_PAGE_PROG 8'h32
`define OP_PROT_WRITE 8'h42
`define OP_WAKE_READ_ID 8'hab
`define OP_DEEP_SLEEP 8'hb9
`define OP_CONFIG_WRITE 8'h01
`define ADDR_MSB 20
`define SECTOR_LSB 12
`define BLOCK64_LSB 16
`define BLOCK32_LSB 15
`define BLOCK8_LSB 13
`define PAGE_MAX_BYTES 9'd256
`define PROT_MAX_BYTES 9'd6
`define RESET_BURST_LEN 7'd8
`define CFG_QUAD_IO_BIT 1
`define STATUS_KEEP_MASK 8'h30
`endif

/* qfcd_skid_buffer.v */
// Purpose: Two-entry buffer between decoder and receiver.
// Assumes: Single clock domain.
// Notes: Full when both entries hold words; in_ready_o stalls the source.
`timescale 1ns/1ps
module qfcd_skid_buffer #(
	parameter WIDTH = 20
) (
	// Clock and reset
	input wire ref_clk_i,
	input wire reset_i,
	// Fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	// Drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_ff [0:1];
	reg wr_ptr_ff;
	reg rd_ptr_ff;
	reg [1:0] count_ff;
	wire push;
	wire pop;
	assign in_ready_o = (count_ff != 2'd2);
	assign out_valid_o = (count_ff != 2'd0);
	assign out_data_o = mem_ff[rd_ptr_ff];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff <= 2'd0;
			mem_ff[0] <= {WIDTH{1'b0}};
			mem_ff[1] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_ff[wr_ptr_ff] <= in_data_i;
				wr_ptr_ff <= ~wr_ptr_ff;
			end
			if (pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			if (push && !pop)
				count_ff <= count_ff + 2'd1;
			else if (pop && !push)
				count_ff <= count_ff - 2'd1;
		end
	end
endmodule // qfcd_skid_buffer

/* quad_flash_command_decoder.v */
// Purpose: Opcode decoder of a serial flash, 1-bit and 4-bit link.
// Assumes: Link clock well below a quarter of ref_clk_i, mode 0 sampling on rising edges.
// Notes: Emits one command word per erase, program or write command through a two-entry buffer.
`timescale 1ns/1ps
`include "qfcd_regs.vh"
// Operation
// - Opcode: two quad clocks, eight single clocks
// - Address/dummy/data bytes: two or eight clocks
// - Dual-width commands use four clocks per byte; none is decoded here
// - Quad page program needs quad-io bit set
// - Address bits above top bit ignored
// - Sector erase 20H, three addresses, A12 up
// - Block erase D8H, size by location
// - Quad page program 32H single mode only
// - Protection write 42H, one to six bytes
// - Wake ABH ends sleep, streams id
// - Reset executes only right after arm; rejected or unknown opcodes in between keep the arm
// - No-operation only cancels reset arm
// - Software reset restores mode, burst, config; status keeps only bits 5:4
module quad_flash_command_decoder (
	// Clock and reset
	input wire ref_clk_i,
	input wire reset_i,
	// Serial link from host
	input wire link_clk_i,
	input wire chip_sel_n_i,
	input wire [3:0] sio_i,
	output wire [3:0] sio_o,
	output wire [3:0] sio_oe_o,
	// Command word out: opcode, erase unit base address, data byte count
	output wire cmd_valid_o,
	input wire cmd_ready_i,
	output wire [7:0] cmd_op_o,
	output wire [`ADDR_MSB:0] cmd_addr_o,
	output wire [8:0] cmd_count_o,
	// Device state
	output wire quad_mode_o,
	output wire quad_io_config_bit_o,
	output wire deep_sleep_o,
	output wire [7:0] status_o,
	output wire [6:0] burst_len_o,
	input wire busy_i,
	input wire [7:0] id_byte_i
);
	localparam S_OP = 5'b00001;
	localparam S_ADDR = 5'b00010;
	localparam S_DATA = 5'b00100;
	localparam S_ID = 5'b01000;
	localparam S_IGN = 5'b10000;
	localparam CW = 8 + `ADDR_MSB + 1 + 9;
	// Three-stage synchronisers for clock, select and data lines.
	reg [2:0] clk_s_ff;
	reg [2:0] cs_s_ff;
	reg [3:0] sio_s1_ff, sio_s2_ff, sio_s3_ff;
	reg clk_lvl_ff, cs_lvl_ff;
	reg [4:0] state_ff;
	reg [7:0] shift_ff;
	reg [3:0] bit_cnt_ff;
	reg [1:0] byte_cnt_ff;
	reg [8:0] data_cnt_ff;
	reg [7:0] op_ff;
	reg [23:0] addr_ff;
	reg [2:0] id_bit_ff;
	reg [7:0] id_sh_ff;
	reg quad_ff, qio_ff, sleep_ff, arm_ff, pend_ff;
	reg [7:0] status_ff;
	reg [6:0] burst_ff;
	wire buf_ready;
	wire rise, fall, cs_on, cs_off, wide;
	wire [3:0] step;
	wire [7:0] shift_nxt;
	reg op_ok;
	integer k;
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_s_ff <= 3'h0;
			cs_s_ff <= 3'h7;
			sio_s1_ff <= 4'h0;
			sio_s2_ff <= 4'h0;
			sio_s3_ff <= 4'h0;
			clk_lvl_ff <= 1'b0;
			cs_lvl_ff <= 1'b1;
		end else begin
			clk_s_ff <= {clk_s_ff[1:0], link_clk_i};
			cs_s_ff <= {cs_s_ff[1:0], chip_sel_n_i};
			sio_s1_ff <= sio_i;
			sio_s2_ff <= sio_s1_ff;
			sio_s3_ff <= sio_s2_ff;
			if (clk_s_ff[1] == clk_s_ff[2])
				clk_lvl_ff <= clk_s_ff[2];
			if (cs_s_ff[1] == cs_s_ff[2])
				cs_lvl_ff <= cs_s_ff[2];
		end
	end
	assign rise = (clk_s_ff[1] == clk_s_ff[2]) && clk_s_ff[2] && !clk_lvl_ff && !cs_lvl_ff;
	assign fall = (clk_s_ff[1] == clk_s_ff[2]) && !clk_s_ff[2] && clk_lvl_ff && !cs_lvl_ff;
	assign cs_off = (cs_s_ff[1] == cs_s_ff[2]) && cs_s_ff[2] && !cs_lvl_ff;
	assign cs_on = (cs_s_ff[1] == cs_s_ff[2]) && !cs_s_ff[2] && cs_lvl_ff;
	// Quad mode moves a nibble per clock, else one bit.
	// Quad page program widens only its data bytes.
	// Its address bytes still take eight clocks on the single line.
	assign wide = quad_ff || (state_ff == S_DATA && op_ff == `OP_QUAD_PAGE_PROG);
	assign step = wide ? 4'd4 : 4'd1;
	assign shift_nxt = wide ? {shift_ff[3:0], sio_s3_ff} : {shift_ff[6:0], sio_s3_ff[0]};
	// No dual-width opcode is decoded here, so no four-clock byte arises.
	always @* begin
		op_ok = 1'b0;
		case (shift_nxt)
			`OP_NOP, `OP_RESET_ARM, `OP_RESET_EXEC, `OP_QUAD_EXIT, `OP_SECTOR_ERASE,
			`OP_BLOCK_ERASE, `OP_CHIP_ERASE, `OP_PAGE_PROG, `OP_PROT_WRITE,
			`OP_WAKE_READ_ID, `OP_DEEP_SLEEP, `OP_CONFIG_WRITE: op_ok = 1'b1;
			// Quad page program only in single mode.
			// And only with the quad-io bit set.
			`OP_QUAD_PAGE_PROG: op_ok = !quad_ff && qio_ff;
			`OP_QUAD_ENTER: op_ok = !quad_ff;
			default: op_ok = 1'b0;
		endcase
	end
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= S_OP;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 4'h0;
			byte_cnt_ff <= 2'd0;
			data_cnt_ff <= 9'd0;
			op_ff <= 8'h00;
			addr_ff <= 24'h000000;
			id_bit_ff <= 3'd0;
			id_sh_ff <= 8'h00;
			quad_ff <= 1'b0;
			qio_ff <= 1'b0;
			sleep_ff <= 1'b0;
			arm_ff <= 1'b0;
			pend_ff <= 1'b0;
			status_ff <= 8'h00;
			burst_ff <= `RESET_BURST_LEN;
		end else begin
			// The hand-over clears first so that a new request in the same cycle wins.
			// A busy receiver keeps the word pending instead of dropping it.
			if (pend_ff && buf_ready && !busy_i)
				pend_ff <= 1'b0;
			if (cs_on) begin
				state_ff <= S_OP;
				bit_cnt_ff <= 4'h0;
				byte_cnt_ff <= 2'd0;
				data_cnt_ff <= 9'd0;
			end else if (cs_off) begin
				if ((state_ff == S_DATA) && (data_cnt_ff != 9'd0))
					pend_ff <= 1'b1;
				state_ff <= S_IGN;
			end else if (rise) begin
				case (state_ff)
					S_OP: begin
						shift_ff <= shift_nxt;
						bit_cnt_ff <= bit_cnt_ff + step;
						if (bit_cnt_ff + step == 4'd8) begin
							bit_cnt_ff <= 4'h0;
							op_ff <= shift_nxt;
							// Any accepted opcode other than arm disarms.
							arm_ff <= 1'b0;
							// Unknown or wrong-mode opcodes sink the frame.
							if (!op_ok || (sleep_ff && shift_nxt != `OP_WAKE_READ_ID)) begin
								arm_ff <= arm_ff;
								state_ff <= S_IGN;
							end else case (shift_nxt)
								`OP_RESET_ARM: begin
									arm_ff <= 1'b1;
									state_ff <= S_IGN;
								end
								`OP_RESET_EXEC: begin
									// Reset restores mode, burst and config; status keeps only bits 5:4.
									if (arm_ff) begin
										quad_ff <= 1'b0;
										qio_ff <= 1'b0;
										burst_ff <= `RESET_BURST_LEN;
										status_ff <= status_ff & `STATUS_KEEP_MASK;
									end
									state_ff <= S_IGN;
								end
								// Nothing else changes on a no-operation.
								`OP_NOP: state_ff <= S_IGN;
								`OP_QUAD_ENTER: begin
									quad_ff <= 1'b1;
									state_ff <= S_IGN;
								end
								`OP_QUAD_EXIT: begin
									quad_ff <= 1'b0;
									state_ff <= S_IGN;
								end
								`OP_DEEP_SLEEP: begin
									sleep_ff <= 1'b1;
									state_ff <= S_IGN;
								end
								// Chip erase carries no cycles after the opcode.
								`OP_CHIP_ERASE: begin
									pend_ff <= 1'b1;
									state_ff <= S_IGN;
								end
								// Protection and config writes go straight to data.
								`OP_PROT_WRITE, `OP_CONFIG_WRITE: state_ff <= S_DATA;
								// Wake ends sleep at the opcode.
								`OP_WAKE_READ_ID: begin
									sleep_ff <= 1'b0;
									state_ff <= S_ADDR;
								end
								default: state_ff <= S_ADDR;
							endcase
						end
					end
					S_ADDR: begin
						shift_ff <= shift_nxt;
						bit_cnt_ff <= bit_cnt_ff + step;
						if (bit_cnt_ff + step == 4'd8) begin
							bit_cnt_ff <= 4'h0;
							addr_ff <= {addr_ff[15:0], shift_nxt};
							byte_cnt_ff <= byte_cnt_ff + 2'd1;
							if (byte_cnt_ff == 2'd2) begin
								if (op_ff == `OP_SECTOR_ERASE || op_ff == `OP_BLOCK_ERASE) begin
									pend_ff <= 1'b1;
									state_ff <= S_IGN;
								end else if (op_ff == `OP_WAKE_READ_ID)
									state_ff <= S_ID;
								else
									state_ff <= S_DATA;
							end
						end
					end
					S_DATA: begin
						shift_ff <= shift_nxt;
						bit_cnt_ff <= bit_cnt_ff + step;
						if (bit_cnt_ff + step == 4'd8) begin
							bit_cnt_ff <= 4'h0;
							if (op_ff == `OP_CONFIG_WRITE && data_cnt_ff == 9'd1)
								qio_ff <= shift_nxt[`CFG_QUAD_IO_BIT];
							if (op_ff == `OP_CONFIG_WRITE && data_cnt_ff == 9'd0)
								status_ff <= shift_nxt;
							// Page data stops counting at one page.
							if ((op_ff == `OP_PROT_WRITE && data_cnt_ff == `PROT_MAX_BYTES) ||
								data_cnt_ff == `PAGE_MAX_BYTES)
								state_ff <= S_IGN;
							else
								data_cnt_ff <= data_cnt_ff + 9'd1;
						end
					end
					default: state_ff <= state_ff;
				endcase
			end
			if (state_ff == S_ID && fall) begin
				id_bit_ff <= id_bit_ff + 3'd1;
				id_sh_ff <= (id_bit_ff == 3'd0) ? id_byte_i : {id_sh_ff[6:0], 1'b0};
			end else if (state_ff != S_ID) begin
				id_bit_ff <= 3'd0;
			end
		end
	end
	// Bits above the density's top bit are dropped.
	// Sector erase keeps A12 and up; block erase aligns by location.
	reg [`ADDR_MSB:0] unit_addr;
	always @* begin
		unit_addr = addr_ff[`ADDR_MSB:0];
		for (k = 0; k <= `ADDR_MSB; k = k + 1) begin
			if (op_ff == `OP_SECTOR_ERASE && k < `SECTOR_LSB)
				unit_addr[k] = 1'b0;
			if (op_ff == `OP_BLOCK_ERASE && k < `BLOCK64_LSB)
				unit_addr[k] = 1'b0;
		end
		if (op_ff == `OP_BLOCK_ERASE && addr_ff[`ADDR_MSB:`BLOCK64_LSB] == 5'h00)
			unit_addr[`BLOCK64_LSB-1:`BLOCK8_LSB] = addr_ff[`BLOCK64_LSB-1:`BLOCK8_LSB];
		if (op_ff == `OP_BLOCK_ERASE && addr_ff[`ADDR_MSB:`BLOCK64_LSB] == 5'h1f)
			unit_addr[`BLOCK64_LSB-1:`BLOCK8_LSB] = addr_ff[`BLOCK64_LSB-1:`BLOCK8_LSB];
	end
	// A stalled receiver holds the word in pend_ff until the buffer takes it.
	qfcd_skid_buffer #(
		.WIDTH(CW)
	) u_buf (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.in_valid_i(pend_ff && !busy_i),
		.in_ready_o(buf_ready),
		.in_data_i({op_ff, unit_addr, data_cnt_ff}),
		.out_valid_o(cmd_valid_o),
		.out_ready_i(cmd_ready_i),
		.out_data_o({cmd_op_o, cmd_addr_o, cmd_count_o})
	);
	assign sio_o = {2'b00, id_sh_ff[7], 1'b0};
	assign sio_oe_o = {2'b00, (state_ff == S_ID) && !cs_lvl_ff, 1'b0};
	assign quad_mode_o = quad_ff;
	assign quad_io_config_bit_o = qio_ff;
	assign deep_sleep_o = sleep_ff;
	assign status_o = status_ff;
	assign burst_len_o = burst_ff;
endmodule // quad_flash_command_decoder

/* qfcd_host_model.sv */
// Purpose: Host controller model driving the serial link of the decoder.
// Assumes: Mode 0: data set while the link clock is low, taken on its rise.
// Notes: The link clock stands low between frames; released lines show inverted data.
`timescale 1ns/1ps
module qfcd_host_model (
	// Link towards the device
	output logic link_clk_o,
	output logic chip_sel_n_o,
	output logic [3:0] sio_o
);
	initial begin
		link_clk_o = 1'b0;
		chip_sel_n_o = 1'b1;
		sio_o = 4'h5;
	end
	task start();
		chip_sel_n_o = 1'b0;
		#40;
	endtask
	task put(input logic [7:0] b, input logic q);
		logic [7:0] s;
		s = b;
		repeat (q ? 2 : 8) begin
			sio_o = q ? s[7:4] : {3'h7, s[7]};
			s = q ? s << 4 : s << 1;
			#40 link_clk_o = 1'b1;
			#40 link_clk_o = 1'b0;
		end
	endtask
	task stop();
		#40 chip_sel_n_o = 1'b1;
		sio_o = ~sio_o;
		#400;
	endtask
endmodule // qfcd_host_model

/* quad_flash_command_decoder_asserts.sv */
// Purpose: Port checks of the command decoder.
// Assumes: Words are judged while they wait at the buffer head.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
module quad_flash_command_decoder_asserts (
	// Watched ports
	input wire ref_clk_i,
	input wire reset_i,
	input wire chip_sel_n_i,
	input wire [3:0] sio_oe_o,
	input wire cmd_valid_o,
	input wire cmd_ready_i,
	input wire [7:0] cmd_op_o,
	input wire [20:0] cmd_addr_o,
	input wire [8:0] cmd_count_o,
	input wire quad_mode_o,
	input wire quad_io_config_bit_o,
	input wire [6:0] burst_len_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	AST_RESET_OUT: assert property (
		$fell(reset_i) |-> !cmd_valid_o && !quad_mode_o && burst_len_o == 7'h08)
		else $error("outputs not at reset values");
	AST_BURST_ONLY_RESET: assert property (
		$changed(burst_len_o) |-> burst_len_o == 7'h08)
		else $error("burst length left eight");
	AST_WORD_HOLD: assert property (
		cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_op_o)
		&& $stable(cmd_addr_o) && $stable(cmd_count_o))
		else $error("stalled word changed");
	AST_SECTOR_WORD: assert property (
		cmd_valid_o && cmd_op_o == 8'h20 |-> cmd_addr_o[11:0] == 12'h000 && cmd_count_o == 9'h000)
		else $error("sector erase word malformed");
	AST_BLOCK_WORD: assert property (
		cmd_valid_o && cmd_op_o == 8'hd8 |-> cmd_addr_o[12:0] == 13'h0000 && cmd_count_o == 9'h000)
		else $error("block erase word malformed");
	AST_PAGE_COUNT: assert property (
		cmd_valid_o && (cmd_op_o == 8'h02 || cmd_op_o == 8'h32) |-> cmd_count_o != 9'h000
		&& cmd_count_o <= 9'h100)
		else $error("page program count out of range");
	AST_PROT_COUNT: assert property (
		cmd_valid_o && cmd_op_o == 8'h42 |-> cmd_count_o != 9'h000 && cmd_count_o <= 9'h006)
		else $error("protection write count out of range");
	AST_QUAD_PP_MODE: assert property (
		cmd_valid_o && cmd_op_o == 8'h32 |-> quad_io_config_bit_o && !quad_mode_o)
		else $error("quad page program taken without its mode");
	AST_OE_IDLE: assert property (
		chip_sel_n_i [*8] |-> sio_oe_o == 4'h0)
		else $error("data line driven outside a frame");
endmodule // quad_flash_command_decoder_asserts
bind quad_flash_command_decoder quad_flash_command_decoder_asserts u_chk (.ref_clk_i, .reset_i,
	.chip_sel_n_i, .sio_oe_o, .cmd_valid_o, .cmd_ready_i, .cmd_op_o, .cmd_addr_o, .cmd_count_o,
	.quad_mode_o, .quad_io_config_bit_o, .burst_len_o);

/* quad_flash_command_decoder_bench.sv */
// Purpose: Self-checking bench of the command decoder.
// Assumes: Link clock of 80 ns from the host model.
// Notes: Each frame ends with a gap long enough for its word to land.
`timescale 1ns/1ps
module quad_flash_command_decoder_bench;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cmd_ready_i = 1'b1;
	logic busy_i = 1'b0;
	logic oe_seen = 1'b0;
	logic [7:0] id_byte_i = 8'h5a;
	logic [7:0] id_got = 8'h00;
	wire link_clk, chip_sel_n, cmd_valid_o, quad_mode_o, qio, deep_sleep_o;
	wire [3:0] h_sio, d_sio, d_oe;
	wire [7:0] cmd_op_o, status_o;
	wire [20:0] cmd_addr_o;
	wire [8:0] cmd_count_o;
	wire [6:0] burst_len_o;
	logic [37:0] words[$];
	int errors = 0;
	int cmp_count = 0;
	int n;
	qfcd_host_model u_h (.link_clk_o(link_clk), .chip_sel_n_o(chip_sel_n), .sio_o(h_sio));
	quad_flash_command_decoder u_dut (.ref_clk_i, .reset_i, .link_clk_i(link_clk),
		.chip_sel_n_i(chip_sel_n), .sio_i({h_sio[3:2], d_oe[1] ? d_sio[1] : h_sio[1], h_sio[0]}),
		.sio_o(d_sio), .sio_oe_o(d_oe), .cmd_valid_o, .cmd_ready_i, .cmd_op_o, .cmd_addr_o,
		.cmd_count_o, .quad_mode_o, .quad_io_config_bit_o(qio), .deep_sleep_o, .status_o,
		.burst_len_o, .busy_i, .id_byte_i);
	always #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		if (cmd_valid_o === 1'b1 && cmd_ready_i)
			words.push_back({cmd_op_o, cmd_addr_o, cmd_count_o});
		if (d_oe[1] === 1'b1)
			oe_seen = 1'b1;
	end
	// The host takes each id bit on the link clock's rise, as a real controller would.
	always @(posedge link_clk) begin
		if (d_oe[1] === 1'b1)
			id_got <= {id_got[6:0], d_sio[1]};
	end
	task chk(input logic [37:0] got, input logic [37:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task complete_run();
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bytes go first-to-last from the top; the last nq bytes travel on four lines.
	task fr(input logic [63:0] b, input int nb, input logic q, input int nq);
		@(posedge ref_clk_i) #1;
		u_h.start();
		for (int i = nb - 1; i >= 0; i--)
			u_h.put(b[i*8 +: 8], q || i < nq);
		u_h.stop();
	endtask
	task opc(input logic [7:0] op, input logic [8:0] cnt);
		chk({words[$][37:30], words[$][8:0]}, {op, cnt});
	endtask
	task t_erase();
		fr(64'h20e53abc, 4, 0, 0);
		chk(words[$], {8'h20, 21'h053000, 9'h000});
		fr(64'hd8003fff, 4, 0, 0);
		chk(words[$], {8'hd8, 21'h002000, 9'h000});
		fr(64'hd8f12345, 4, 0, 0);
		chk(words[$], {8'hd8, 21'h110000, 9'h000});
		fr(64'hc7, 1, 0, 0);
		opc(8'hc7, 9'h000);
	endtask
	task t_prot_cfg();
		fr(64'h42010203040506, 7, 0, 0);
		opc(8'h42, 9'h006);
		fr(64'h013c02, 3, 0, 0);
		chk({status_o, qio}, {8'h3c, 1'b1});
		fr(64'h32000100a1a2a3, 7, 0, 3);
		opc(8'h32, 9'h003);
	endtask
	task t_quad();
		fr(64'h38, 1, 0, 0);
		chk(quad_mode_o, 1'b1);
		n = words.size();
		fr(64'h32000100a1, 5, 1, 0);
		chk(38'(words.size()), 38'(n));
		fr(64'h02000100b1b2, 6, 1, 0);
		opc(8'h02, 9'h002);
		fr(64'h4207, 2, 1, 0);
		opc(8'h42, 9'h001);
	endtask
	task t_soft_reset();
		fr(64'h66, 1, 1, 0);
		fr(64'h00, 1, 1, 0);
		fr(64'h99, 1, 1, 0);
		chk({quad_mode_o, qio}, 2'b11);
		fr(64'h66, 1, 1, 0);
		fr(64'h99, 1, 1, 0);
		chk({quad_mode_o, qio, status_o, burst_len_o}, {2'b00, 8'h30, 7'h08});
	endtask
	task t_sleep();
		fr(64'hb9, 1, 0, 0);
		chk(deep_sleep_o, 1'b1);
		n = words.size();
		fr(64'hc7, 1, 0, 0);
		chk(38'(words.size()), 38'(n));
		fr(64'hab00000000, 5, 0, 0);
		chk({deep_sleep_o, oe_seen}, 2'b01);
		chk(38'(id_got), 38'h5a);
	endtask
	task t_buffer();
		@(posedge ref_clk_i) #1 cmd_ready_i = 1'b0;
		n = words.size();
		fr(64'hc7, 1, 0, 0);
		fr(64'hc7, 1, 0, 0);
		chk({cmd_valid_o, 37'(words.size())}, {1'b1, 37'(n)});
		@(posedge ref_clk_i) #1 cmd_ready_i = 1'b1;
		busy_i = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		fr(64'hc7, 1, 0, 0);
		chk(38'(words.size()), 38'(n + 2));
		@(posedge ref_clk_i) #1 busy_i = 1'b0;
		repeat (10) @(posedge ref_clk_i);
		chk(38'(words.size()), 38'(n + 3));
	endtask
	initial begin
		repeat (6) @(posedge ref_clk_i);
		#1 reset_i = 1'b0;
		repeat (10) @(posedge ref_clk_i);
		chk({cmd_valid_o, quad_mode_o, qio, deep_sleep_o, status_o, burst_len_o}, 19'h8);
		t_erase();
		t_prot_cfg();
		t_quad();
		t_soft_reset();
		t_sleep();
		t_buffer();
		complete_run();
	end
	initial begin
		#100000;
		errors++;
		complete_run();
	end
endmodule // quad_flash_command_decoder_bench
